// ---- logic/usm_pkg.sv ----
// constants shared by the serial mode configuration and irq mask block
//------------------------------------------------------------------
//------------------------------------------------------------------
package usm_pkg;
   // register byte addresses
   localparam logic [31:0] ADDR_MODE_CFG   = 32'h4002_4004;
   localparam logic [31:0] ADDR_IRQ_SET    = 32'h4002_4008;
   localparam logic [31:0] ADDR_IRQ_CLR    = 32'h4002_400c;
   localparam logic [31:0] ADDR_IRQ_MASK   = 32'h4002_4010;
   localparam logic [31:0] ADDR_IRQ_STAT   = 32'h4002_4014;
   localparam logic [31:0] ADDR_STAT_CLR   = 32'h4002_4018;
   localparam logic [31:0] ADDR_WPROT      = 32'h4002_40e4;
   // mode register fields
   localparam int MODE_LSB   = 0;
   localparam int CLKSRC_LSB = 4;
   localparam int CHAR_LENGTH_FIELD_LSB   = 6;
   localparam int SPI_CLOCK_PHASE_BIT   = 8;
   localparam int SPI_CLOCK_POLARITY_BIT   = 16;
   localparam int SERIAL_CLOCK_DRIVE_EN_BIT   = 18;
   localparam int OVER_BIT   = 19;
   localparam int WAIT_RX_READ_BEFORE_SEND_BIT  = 20;
   localparam int FILTER_BIT = 28;
   localparam logic [31:0] MODE_CFG_WMASK = 32'h101d_01ff;
   localparam logic [31:0] MODE_CFG_RESET = 32'h0000_0000;
   localparam logic [3:0]  OPMODE_SPI_MASTER = 4'he;
   localparam logic [3:0]  OPMODE_SPI_SLAVE  = 4'hf;
   localparam logic [1:0]  CLKSRC_PCLK = 2'h0;
   localparam logic [1:0]  CLKSRC_DIV  = 2'h1;
   localparam logic [1:0]  CLKSRC_PIN  = 2'h3;
   localparam logic [1:0]  CHAR_LENGTH_FIELD_8BIT   = 2'h3;
   localparam logic [3:0]  CHAR_BITS_MIN = 4'h5;
   localparam logic [3:0]  CHAR_BITS_SPI = 4'h8;
   // clock divide and oversampling counts
   localparam logic [2:0]  DIV_LAST   = 3'h7;
   localparam logic [3:0]  OS16_LAST  = 4'hf;
   localparam logic [3:0]  OS8_LAST   = 4'h7;
   // interrupt source layout
   localparam int IRQ_W = 20;
   localparam logic [IRQ_W-1:0] IRQ_VALID_ASYNC = 20'h8_1bff;
   localparam logic [IRQ_W-1:0] IRQ_VALID_SPI   = 20'h0_1e3b;
   localparam logic [IRQ_W-1:0] IRQ_VALID_DMA   = 20'h0_1818;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET  = 20'h0_0000;
   localparam logic [IRQ_W-1:0] IRQ_STAT_RESET  = 20'h0_0000;
   localparam int WPROT_BIT = 0;
endpackage

// ---- logic/usm_rx_filter.sv ----
// receive line majority filter
`timescale 1ns/10ps
module usm_rx_filter
   import usm_pkg::*;
(
   input  wire logic pclk,        // peripheral clock
   input  wire logic presetn,     // async reset, low
   input  wire logic ce,          // clock enable
   input  wire logic sample_tick, // one-sixteenth or one-eighth bit tick
   input  wire logic filter_en,   // filter selected
   input  wire logic rx_in,       // synchronised line
   output logic      rx_out       // filtered line
);
   logic [2:0] taps;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         taps <= 3'h7;
      else if (ce && sample_tick)
         taps <= {taps[1:0], rx_in};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rx_out <= 1'b1;
      else if (ce)
      begin
         if (filter_en)
            rx_out <= (taps[0] & taps[1]) | (taps[1] & taps[2])
                      | (taps[0] & taps[2]);
         else
            rx_out <= rx_in;
      end
   end

   AST_FILTER_VOTE: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && filter_en && taps == 3'h0) |=> !rx_out)
      else $error("majority filter did not follow samples");
endmodule // usm_rx_filter

// ---- logic/usm_top.sv ----
// serial port mode configuration, interrupt mask and clock control
`timescale 1ns/10ps
module usm_top
   import usm_pkg::*;
(
   input  wire logic             pclk,            // peripheral clock
   input  wire logic             presetn,         // async reset, low
   input  wire logic             ce,              // clock enable
   input  wire logic             psel,            // apb select
   input  wire logic             penable,         // apb enable
   input  wire logic             pwrite,          // apb direction
   input  wire logic [31:0]      paddr,           // apb address
   input  wire logic [31:0]      pwdata,          // apb write data
   output logic      [31:0]      prdata,          // apb read data
   output logic                  pready,          // apb ready
   output logic                  pslverr,         // apb error
   input  wire logic [IRQ_W-1:0] evt_pulse,       // source event pulses
   output logic                  irq,             // level interrupt
   input  wire logic             rx_pin,          // receive line pin
   input  wire logic             sclk_in,         // serial clock pin in
   output logic                  sclk_out,        // serial clock pin out
   output logic                  sclk_oe,         // serial clock drive
   input  wire logic             tx_write,        // tx holding written
   input  wire logic             tx_holding_free, // tx holding empty
   input  wire logic             rx_holding_full, // rx holding full
   input  wire logic             xfer_active,     // character in flight
   output logic                  tx_start,        // start character
   output logic                  rx_filtered,     // filtered rx line
   output logic                  sample_tick,     // oversample tick
   output logic                  bit_tick,        // one per bit time
   output logic                  spi_mode,        // spi view active
   output logic                  change_leading,  // data change edge
   output logic [3:0]            char_bits        // character length
);
   //---------------------------------------------------------------
   // registers and decode
   //---------------------------------------------------------------
   logic [31:0]      mode_cfg;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] irq_stat;
   logic             write_protect_enable;
   logic             acc;
   logic             wr_en;
   logic             hit;
   logic [IRQ_W-1:0] valid_bits;
   logic [IRQ_W-1:0] set_bits;
   logic [IRQ_W-1:0] clr_bits;
   logic [IRQ_W-1:0] stat_clr;
   logic [3:0]       op_mode;
   logic [1:0]       clock_source_select;
   logic [1:0]       char_length_field;
   logic             spi_view;

   assign op_mode             = mode_cfg[MODE_LSB +: 4];
   assign clock_source_select = mode_cfg[CLKSRC_LSB +: 2];
   assign char_length_field   = mode_cfg[CHAR_LENGTH_FIELD_LSB +: 2];
   assign spi_view = (op_mode == OPMODE_SPI_MASTER)
                     || (op_mode == OPMODE_SPI_SLAVE);
   assign valid_bits = (spi_view ? IRQ_VALID_SPI : IRQ_VALID_ASYNC)
                       | IRQ_VALID_DMA;

   assign acc   = psel && penable && pready;
   assign wr_en = ce && acc && pwrite;
   assign hit = (paddr == ADDR_MODE_CFG) || (paddr == ADDR_IRQ_SET)
                || (paddr == ADDR_IRQ_CLR) || (paddr == ADDR_IRQ_MASK)
                || (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_STAT_CLR)
                || (paddr == ADDR_WPROT);
   assign set_bits = (wr_en && paddr == ADDR_IRQ_SET)
                     ? pwdata[IRQ_W-1:0] & valid_bits : '0;
   assign clr_bits = (wr_en && paddr == ADDR_IRQ_CLR)
                     ? pwdata[IRQ_W-1:0] : '0;
   assign stat_clr = (wr_en && paddr == ADDR_STAT_CLR)
                     ? pwdata[IRQ_W-1:0] : '0;

   //---------------------------------------------------------------
   // apb slave: one wait state, then data
   //---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b0;
      else if (ce)
         pready <= psel && penable && !pready;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (ce)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         if (psel && penable && !pready)
         begin
            pslverr <= !hit;
            if (!pwrite)
            begin
               unique case (paddr)
                  ADDR_MODE_CFG: prdata <= mode_cfg;
                  ADDR_IRQ_MASK: prdata <= {{(32-IRQ_W){1'b0}}, irq_mask};
                  ADDR_IRQ_STAT: prdata <= {{(32-IRQ_W){1'b0}}, irq_stat};
                  ADDR_WPROT:
                     prdata <= {31'h0000_0000, write_protect_enable};
                  default:       prdata <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode_cfg <= MODE_CFG_RESET;
      else if (wr_en && paddr == ADDR_MODE_CFG
               && !write_protect_enable)
         mode_cfg <= pwdata & MODE_CFG_WMASK;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         write_protect_enable <= 1'b0;
      else if (wr_en && paddr == ADDR_WPROT)
         write_protect_enable <= pwdata[WPROT_BIT];
   end

   //---------------------------------------------------------------
   // interrupt status, mask and output
   //---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_mask <= IRQ_MASK_RESET;
      else if (ce)
         irq_mask <= (irq_mask | set_bits) & ~clr_bits;
   end

   // new events win over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat <= IRQ_STAT_RESET;
      else if (ce)
         irq_stat <= (irq_stat & ~stat_clr) | evt_pulse;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else if (ce)
         irq <= |(irq_stat & irq_mask & valid_bits);
   end

   //---------------------------------------------------------------
   // pin synchronisers
   //---------------------------------------------------------------
   logic [1:0] rx_sync;
   logic [2:0] sclk_sync;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_sync   <= 2'h3;
         sclk_sync <= 3'h0;
      end
      else if (ce)
      begin
         rx_sync   <= {rx_sync[0], rx_pin};
         sclk_sync <= {sclk_sync[1:0], sclk_in};
      end
   end

   //---------------------------------------------------------------
   // clock source, oversampling and bit ticks
   //---------------------------------------------------------------
   logic [2:0] div_cnt;
   logic [3:0] os_cnt;
   logic [3:0] os_last;
   logic       next_sample;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_cnt <= 3'h0;
      else if (ce)
         div_cnt <= div_cnt + 3'h1;
   end

   always_comb
   begin
      unique case (clock_source_select)
         CLKSRC_PCLK: next_sample = 1'b1;
         CLKSRC_DIV:  next_sample = (div_cnt == DIV_LAST);
         CLKSRC_PIN:  next_sample = sclk_sync[1] && !sclk_sync[2];
         default:     next_sample = 1'b0;
      endcase
   end

   assign os_last = mode_cfg[OVER_BIT] ? OS8_LAST : OS16_LAST;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sample_tick <= 1'b0;
      else if (ce)
         sample_tick <= next_sample;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         os_cnt   <= 4'h0;
         bit_tick <= 1'b0;
      end
      else if (ce)
      begin
         bit_tick <= 1'b0;
         if (sample_tick)
         begin
            if (os_cnt >= os_last)
            begin
               os_cnt   <= 4'h0;
               bit_tick <= 1'b1;
            end
            else
               os_cnt <= os_cnt + 4'h1;
         end
      end
   end

   usm_rx_filter u_filter (
      .pclk        (pclk),
      .presetn     (presetn),
      .ce          (ce),
      .sample_tick (sample_tick),
      .filter_en   (mode_cfg[FILTER_BIT]),
      .rx_in       (rx_sync[1]),
      .rx_out      (rx_filtered)
   );

   //---------------------------------------------------------------
   // serial clock pin and spi configuration outputs
   //---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sclk_oe  <= 1'b0;
         sclk_out <= 1'b0;
      end
      else if (ce)
      begin
         sclk_oe <= mode_cfg[SERIAL_CLOCK_DRIVE_EN_BIT]
                    && (clock_source_select != CLKSRC_PIN);
         if (!xfer_active)
            sclk_out <= mode_cfg[SPI_CLOCK_POLARITY_BIT];
         else if (bit_tick)
            sclk_out <= !sclk_out;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         spi_mode       <= 1'b0;
         change_leading <= 1'b1;
         char_bits      <= CHAR_BITS_MIN;
      end
      else if (ce)
      begin
         spi_mode       <= spi_view;
         change_leading <= !mode_cfg[SPI_CLOCK_PHASE_BIT];
         if (spi_view)
            char_bits <= CHAR_BITS_SPI;
         else
            char_bits <= CHAR_BITS_MIN + {2'h0, char_length_field};
      end
   end

   //---------------------------------------------------------------
   // transmit start gating
   //---------------------------------------------------------------
   logic tx_pending;
   logic go;

   assign go = tx_pending
               && (!mode_cfg[WAIT_RX_READ_BEFORE_SEND_BIT] || !rx_holding_full);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tx_pending <= 1'b0;
      else if (ce)
      begin
         if (tx_write && tx_holding_free)
            tx_pending <= 1'b1;
         else if (go)
            tx_pending <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tx_start <= 1'b0;
      else if (ce)
         tx_start <= go;
   end

   //---------------------------------------------------------------
   // assertions
   //---------------------------------------------------------------
   AST_WP_BLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == ADDR_MODE_CFG && write_protect_enable)
      |=> $stable(mode_cfg))
      else $error("mode written while protected");
   AST_MODE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == ADDR_MODE_CFG && !write_protect_enable)
      |=> mode_cfg == ($past(pwdata) & MODE_CFG_WMASK))
      else $error("mode write lost");
   AST_IRQ_SET: assert property (@(posedge pclk) disable iff (!presetn)
      (set_bits != '0) |=> ((irq_mask & $past(set_bits))
                            == $past(set_bits)))
      else $error("enable set failed");
   AST_IRQ_CLR: assert property (@(posedge pclk) disable iff (!presetn)
      (clr_bits != '0) |=> ((irq_mask & $past(clr_bits)) == '0))
      else $error("enable clear failed");
   AST_SPI_VALID: assert property (@(posedge pclk) disable iff (!presetn)
      spi_view |-> ((valid_bits & 20'h8_01c4) == '0))
      else $error("async-only source valid in spi view");
   AST_DMA_VALID: assert property (@(posedge pclk) disable iff (!presetn)
      (valid_bits & IRQ_VALID_DMA) == IRQ_VALID_DMA)
      else $error("dma source not valid");
   AST_ASYNC_VALID: assert property (@(posedge pclk) disable iff (!presetn)
      !spi_view |-> !valid_bits[10])
      else $error("underrun valid outside spi");
   AST_IRQ_OUT: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && |(irq_stat & irq_mask & valid_bits)) |=> irq)
      else $error("interrupt not raised");
   AST_SCLK_OE: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && clock_source_select == CLKSRC_PIN) |=> !sclk_oe)
      else $error("clock pin driven with external source");
   AST_SCLK_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && !xfer_active) |=> sclk_out == $past(mode_cfg[SPI_CLOCK_POLARITY_BIT]))
      else $error("idle clock level wrong");
   AST_WAIT_READ: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && mode_cfg[WAIT_RX_READ_BEFORE_SEND_BIT] && rx_holding_full) |=> !tx_start)
      else $error("start while rx holding full");
   AST_NO_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && tx_write && tx_holding_free && !mode_cfg[WAIT_RX_READ_BEFORE_SEND_BIT])
      ##1 ce |=> tx_start)
      else $error("start not issued after write");
   AST_OS_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
      bit_tick |-> $past(os_cnt) >= $past(os_last))
      else $error("bit tick at wrong oversample count");
   AST_SPI_CHAR: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && spi_view) |=> char_bits == CHAR_BITS_SPI)
      else $error("spi character not 8 bits");
   AST_PHASE: assert property (@(posedge pclk) disable iff (!presetn)
      ce |=> change_leading == !$past(mode_cfg[SPI_CLOCK_PHASE_BIT]))
      else $error("phase output wrong");
   AST_DIV8: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && clock_source_select == CLKSRC_DIV && next_sample)
      |-> div_cnt == DIV_LAST)
      else $error("divided tick off count");

   CV_SPI_MODE: cover property (@(posedge pclk) disable iff (!presetn)
      spi_view && irq);
   CV_WAIT_START: cover property (@(posedge pclk) disable iff (!presetn)
      mode_cfg[WAIT_RX_READ_BEFORE_SEND_BIT] && rx_holding_full && tx_pending
      ##[1:20] tx_start);
   CV_WP_WRITE: cover property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == ADDR_MODE_CFG && write_protect_enable);
   CV_OS8_BIT: cover property (@(posedge pclk) disable iff (!presetn)
      bit_tick && mode_cfg[OVER_BIT]);
endmodule // usm_top

// ---- tb/usm_partner.sv ----
// far-side serial device model: serial clock and receive line
`timescale 1ns/10ps
module usm_partner
(
   input  wire logic pclk,    // bench clock
   input  wire logic frame,   // frame in progress
   input  wire logic spi_clock_polarity,    // clock idle level
   input  wire logic rx_bit,  // level to send
   output logic      sclk_in, // serial clock to device
   output logic      rx_pin   // data line to device
);
   logic [1:0] div;

   initial
   begin
      div = 2'h0;
      sclk_in = 1'b0;
      rx_pin = 1'b1;
   end

   // clock stands at idle level outside frames
   always @(posedge pclk)
   begin
      div <= div + 2'h1;
      if (!frame)
         sclk_in <= spi_clock_polarity;
      else if (div == 2'h3)
         sclk_in <= ~sclk_in;
      rx_pin <= rx_bit;
   end
endmodule // usm_partner

// ---- tb/testbench.sv ----
// self-checking bench for the serial mode and irq mask block
`timescale 1ns/10ps
`define CHK(n, e, s) \
   begin \
      total_checks++; \
      if ((s) !== (e)) \
      begin \
         $display("mismatch %s exp %h got %h", n, e, s); \
         fails++; \
      end \
   end
module testbench
   import usm_pkg::*;
;
   logic             pclk, presetn, psel, penable, pwrite, ce;
   logic [31:0]      paddr, pwdata, prdata, rd, seed, m, v;
   logic             pready, pslverr, irq, sclk_in, sclk_out, sclk_oe;
   logic [IRQ_W-1:0] evt_pulse, em;
   logic             rx_pin, tx_write, tx_holding_free, rx_holding_full;
   logic             xfer_active, tx_start, rx_filtered, sample_tick;
   logic             bit_tick, spi_mode, change_leading, frame, rx_bit;
   logic             err;
   logic [3:0]       char_bits;
   logic [31:0]      corner [4] = '{32'h0005_01ce, 32'h0005_01bf,
                                    32'h1018_00c0, 32'h0004_003e};
   int               fails, total_checks, p;
   int               bit_gap [4] = '{16, 8, 128, 64};
   int               irq_bit [4] = '{0, 9, 12, 19};

   usm_top dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .evt_pulse, .irq, .rx_pin,
      .sclk_in, .sclk_out, .sclk_oe, .tx_write, .tx_holding_free,
      .rx_holding_full, .xfer_active, .tx_start, .rx_filtered,
      .sample_tick, .bit_tick, .spi_mode, .change_leading, .char_bits);

   usm_partner far_end (.pclk, .frame, .spi_clock_polarity(m[SPI_CLOCK_POLARITY_BIT]), .rx_bit,
      .sclk_in, .rx_pin);

   always #5 pclk = ~pclk;

   //------------------------------------------------------------
   // helpers
   //------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [3:0] exp_bits(input logic [31:0] x);
      if (x[3:0] == OPMODE_SPI_MASTER || x[3:0] == OPMODE_SPI_SLAVE)
         return CHAR_BITS_SPI;
      return CHAR_BITS_MIN + {2'h0, x[7:6]};
   endfunction

   function automatic logic [IRQ_W-1:0] valid(input logic spi);
      return (spi ? IRQ_VALID_SPI : IRQ_VALID_ASYNC) | IRQ_VALID_DMA;
   endfunction

   task automatic test_done();
      if (fails == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [31:0] a, d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         fails++;
         test_done();
      end
   endtask

   // cycles between two pulses, 300 when none
   task automatic gap(ref logic s, output int g);
      for (int k = 0; k < 300 && s !== 1'b1; k++)
         @(posedge pclk);
      @(posedge pclk);
      for (g = 1; g < 300 && s !== 1'b1; g++)
         @(posedge pclk);
   endtask

   //------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, frame, tx_write} = '0;
      {paddr, pwdata, evt_pulse, rx_holding_full, xfer_active} = '0;
      {ce, tx_holding_free, rx_bit} = 3'h7;
      seed = 32'h6d4f;
      m = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, ADDR_MODE_CFG, 0);
      `CHK("mode", MODE_CFG_RESET, rd)
      apb(1, 32'h4002_4100, 1);
      `CHK("slverr", 1'b1, err)
      for (int i = 0; i < 12; i++)
      begin
         seed = lfsr(seed);
         m = i < 4 ? corner[i] : seed;
         apb(1, ADDR_MODE_CFG, m);
         apb(0, ADDR_MODE_CFG, 0);
         `CHK("mode", m & MODE_CFG_WMASK, rd)
         `CHK("spi", m[3:0] >= 4'he, spi_mode)
         `CHK("bits", exp_bits(m), char_bits)
         `CHK("phase", ~m[SPI_CLOCK_PHASE_BIT], change_leading)
         `CHK("idle", m[SPI_CLOCK_POLARITY_BIT], sclk_out)
         `CHK("oe", m[SERIAL_CLOCK_DRIVE_EN_BIT] && m[5:4] != 2'h3, sclk_oe)
      end
      apb(1, ADDR_WPROT, 1);
      apb(1, ADDR_MODE_CFG, ~m);
      apb(0, ADDR_MODE_CFG, 0);
      `CHK("locked", m & MODE_CFG_WMASK, rd)
      apb(1, ADDR_WPROT, 0);
      for (int s = 0; s < 2; s++)
      begin
         apb(1, ADDR_MODE_CFG, s ? 32'hf : 32'h0);
         apb(1, ADDR_IRQ_CLR, 32'hf_ffff);
         em = '0;
         for (int i = 0; i < 6; i++)
         begin
            seed = lfsr(seed);
            v = i == 0 ? 32'hf_ffff : (i < 3 ? 32'h0 : seed);
            apb(1, i[0] ? ADDR_IRQ_CLR : ADDR_IRQ_SET, v);
            em = i[0] ? em & ~v[IRQ_W-1:0] : em | (v[IRQ_W-1:0] & valid(s));
            apb(0, ADDR_IRQ_MASK, 0);
            `CHK("mask", em, rd[IRQ_W-1:0])
         end
      end
      apb(1, ADDR_MODE_CFG, 0);
      apb(1, ADDR_IRQ_CLR, 32'hf_ffff);
      foreach (irq_bit[i])
      begin
         v = 32'h1 << irq_bit[i];
         evt_pulse <= v[IRQ_W-1:0];
         @(posedge pclk);
         evt_pulse <= '0;
         repeat (3) @(posedge pclk);
         `CHK("irq_off", 1'b0, irq)
         apb(1, ADDR_IRQ_SET, v);
         repeat (2) @(posedge pclk);
         `CHK("irq_on", 1'b1, irq)
         apb(1, ADDR_IRQ_CLR, v);
         repeat (2) @(posedge pclk);
         `CHK("irq_dis", 1'b0, irq)
         apb(1, ADDR_IRQ_SET, v);
         apb(1, ADDR_STAT_CLR, v);
         repeat (2) @(posedge pclk);
         `CHK("irq_clr", 1'b0, irq)
         apb(1, ADDR_IRQ_CLR, v);
      end
      for (int w = 0; w < 2; w++)
      begin
         apb(1, ADDR_MODE_CFG, w ? 32'h10_000e : 32'he);
         rx_holding_full <= w[0];
         @(posedge pclk);
         tx_write <= 1'b1;
         @(posedge pclk);
         tx_write <= 1'b0;
         repeat (w ? 6 : 2) @(posedge pclk);
         `CHK("start", ~w[0], tx_start)
         rx_holding_full <= 1'b0;
         for (p = 0; p < 4 && w && tx_start !== 1'b1; p++)
            @(posedge pclk);
         if (!w)
            @(posedge pclk);
         `CHK("start_end", w[0], tx_start)
      end
      foreach (bit_gap[i])
      begin
         apb(1, ADDR_MODE_CFG, {12'h0, i[0], 14'h0, i[1], 4'h0});
         gap(bit_tick, p);
         `CHK("bit_gap", bit_gap[i], p)
      end
      gap(sample_tick, p);
      `CHK("div_gap", 8, p)
      apb(1, ADDR_MODE_CFG, 32'h30);
      frame <= 1'b1;
      gap(sample_tick, p);
      `CHK("pin_gap", 8, p)
      frame <= 1'b0;
      apb(1, ADDR_MODE_CFG, 32'h1000_0000);
      rx_bit <= 1'b0;
      repeat (12) @(posedge pclk);
      rx_bit <= 1'b1;
      @(posedge pclk);
      rx_bit <= 1'b0;
      repeat (12) @(posedge pclk);
      `CHK("glitch", 1'b0, rx_filtered)
      rx_bit <= 1'b1;
      repeat (12) @(posedge pclk);
      `CHK("filt", 1'b1, rx_filtered)
      test_done();
   end
endmodule // testbench
